// file: verilog/tpc_channel.sv
// Timer counter with one capture/compare/PWM channel
`timescale 1ns/1ps
`default_nettype none
module tpc_channel (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Register port
  input wire tpc_pkg::tpc_bus_req_t bus,
  output logic [7:0] rdata,
  // Debug halt and alternate count tick
  input wire logic debug_mode,
  input wire logic ext_tick,
  // Channel pin
  input wire logic chan_pin_in,
  output logic chan_pin_out,
  output logic chan_pin_oe,
  // Channel event flag level
  output logic chan_event_flag
);

  tpc_pkg::tpc_state_t s_reg; // Current state
  tpc_pkg::tpc_state_t s_next; // Next state

  logic pin_level; // Clean pin level
  logic pin_rise; // Clean rising edge
  logic pin_fall; // Clean falling edge

  tpc_pkg::tpc_mode_t mode; // Decoded channel mode
  logic tick; // Counter advance enable
  logic [15:0] term; // Terminal count
  logic [15:0] cnext; // Counter value after this cycle
  logic match; // Compare match on this step
  logic is_pwm; // Either PWM mode
  logic pwm_load; // PWM buffered load point
  logic cap_evt; // Active capture edge
  logic evt; // Any flag-setting event
  logic pwm_lvl; // PWM active window

  // Pin synchroniser
  tpc_pin_sync u_sync (
    .clk(clk),
    .reset_n(reset_n),
    .pin(chan_pin_in),
    .level(pin_level),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  // Mode decode from center bit, mode select and edge/level bits
  always_comb begin
    mode = tpc_pkg::TPC_MODE_OFF;
    if (s_reg.els == tpc_pkg::TPC_EL_NONE) begin
      mode = tpc_pkg::TPC_MODE_OFF;
    end else if (s_reg.center) begin
      mode = tpc_pkg::TPC_MODE_CENTER_ALIGNED_PWM;
    end else if (s_reg.msel[1]) begin
      mode = tpc_pkg::TPC_MODE_EDGE_ALIGNED_PWM;
    end else if (s_reg.msel == tpc_pkg::TPC_MS_COMPARE) begin
      mode = tpc_pkg::TPC_MODE_COMPARE;
    end else begin
      mode = tpc_pkg::TPC_MODE_CAPTURE;
    end
  end

  // Counter step: clock source, terminal and direction
  always_comb begin
    tick = 1'b0;
    case (s_reg.clks)
      tpc_pkg::TPC_CLKS_OFF: tick = 1'b0;
      tpc_pkg::TPC_CLKS_BUS: tick = 1'b1;
      default: tick = ext_tick;
    endcase
    // Counter stands still while halted in debug
    if (debug_mode) begin
      tick = 1'b0;
    end
    // Zero modulo means free running
    term = (s_reg.modulo == tpc_pkg::TPC_CNT_ZERO) ?
           tpc_pkg::TPC_CNT_MAX : s_reg.modulo;
    cnext = s_reg.count;
    if (tick) begin
      if (s_reg.center) begin
        if (s_reg.count_up) begin
          cnext = (s_reg.count >= term) ?
                  s_reg.count - tpc_pkg::TPC_CNT_ONE :
                  s_reg.count + tpc_pkg::TPC_CNT_ONE;
        end else begin
          cnext = (s_reg.count == tpc_pkg::TPC_CNT_ZERO) ?
                  tpc_pkg::TPC_CNT_ONE :
                  s_reg.count - tpc_pkg::TPC_CNT_ONE;
        end
      end else begin
        cnext = (s_reg.count >= term) ? tpc_pkg::TPC_CNT_ZERO :
                s_reg.count + tpc_pkg::TPC_CNT_ONE;
      end
    end
  end

  // Event detection for compare, PWM and capture
  always_comb begin
    is_pwm = (mode == tpc_pkg::TPC_MODE_EDGE_ALIGNED_PWM) ||
             (mode == tpc_pkg::TPC_MODE_CENTER_ALIGNED_PWM);
    match = tick && (cnext == s_reg.value) &&
            ((mode == tpc_pkg::TPC_MODE_COMPARE) || is_pwm);
    // PWM load on the step from terminal minus one to terminal
    pwm_load = tick && is_pwm && (cnext == term) &&
               (s_reg.count == term - tpc_pkg::TPC_CNT_ONE);
    // Rising with low bit, falling with high bit
    cap_evt = (mode == tpc_pkg::TPC_MODE_CAPTURE) &&
              ((pin_rise && s_reg.els[0]) ||
               (pin_fall && s_reg.els[1]));
    // No flag at 0% duty; above-terminal values never match
    evt = cap_evt ||
          (match && !(is_pwm &&
                      s_reg.value == tpc_pkg::TPC_CNT_ZERO));
    // Active window; low edge/level bit inverts polarity
    pwm_lvl = (cnext < s_reg.value) ^ s_reg.els[0];
  end

  // Register port, value buffering, flag and pin logic
  always_comb begin
    s_next = s_reg;
    s_next.rdata = 8'h00;

    // Counter and direction
    s_next.count = cnext;
    if (tick && s_reg.center) begin
      if (s_reg.count_up && s_reg.count >= term) begin
        s_next.count_up = 1'b0;
      end else if (!s_reg.count_up &&
                   s_reg.count == tpc_pkg::TPC_CNT_ZERO) begin
        s_next.count_up = 1'b1;
      end
    end
    if (!s_reg.center) begin
      s_next.count_up = 1'b1;
    end

    // Register reads
    if (bus.rd) begin
      case (bus.addr)
        tpc_pkg::TPC_ADDR_TSC: begin
          s_next.rdata[tpc_pkg::TPC_TSC_CENTER] = s_reg.center;
          s_next.rdata[tpc_pkg::TPC_TSC_CLKS_HI] = s_reg.clks[1];
          s_next.rdata[tpc_pkg::TPC_TSC_CLKS_LO] = s_reg.clks[0];
        end
        tpc_pkg::TPC_ADDR_CNTH: s_next.rdata = s_reg.count[15:8];
        tpc_pkg::TPC_ADDR_CNTL: s_next.rdata = s_reg.count[7:0];
        tpc_pkg::TPC_ADDR_MODH: s_next.rdata = s_reg.modulo[15:8];
        tpc_pkg::TPC_ADDR_MODL: s_next.rdata = s_reg.modulo[7:0];
        tpc_pkg::TPC_ADDR_CSC: begin
          s_next.rdata[tpc_pkg::TPC_CSC_FLAG] = s_reg.flag;
          s_next.rdata[tpc_pkg::TPC_CSC_IRQ_EN] = s_reg.irq_en;
          s_next.rdata[tpc_pkg::TPC_CSC_MS_HI] = s_reg.msel[1];
          s_next.rdata[tpc_pkg::TPC_CSC_MS_LO] = s_reg.msel[0];
          s_next.rdata[tpc_pkg::TPC_CSC_EL_HI] = s_reg.els[1];
          s_next.rdata[tpc_pkg::TPC_CSC_EL_LO] = s_reg.els[0];
          // Reading a set flag arms the clear
          if (s_reg.flag) begin
            s_next.flag_armed = 1'b1;
          end
        end
        tpc_pkg::TPC_ADDR_VALH: begin
          if (mode == tpc_pkg::TPC_MODE_CAPTURE && !debug_mode) begin
            if (s_reg.rlatched && !s_reg.rlatch_hi) begin
              // Second half of a low-first read
              s_next.rdata = s_reg.rbuf[15:8];
              s_next.rlatched = 1'b0;
            end else begin
              // First half: snapshot both bytes
              s_next.rdata = s_reg.value[15:8];
              s_next.rbuf = s_reg.value;
              s_next.rlatched = 1'b1;
              s_next.rlatch_hi = 1'b1;
            end
          end else begin
            // Live contents, latch untouched in debug
            s_next.rdata = s_reg.value[15:8];
          end
        end
        tpc_pkg::TPC_ADDR_VALL: begin
          if (mode == tpc_pkg::TPC_MODE_CAPTURE && !debug_mode) begin
            if (s_reg.rlatched && s_reg.rlatch_hi) begin
              // Second half of a high-first read
              s_next.rdata = s_reg.rbuf[7:0];
              s_next.rlatched = 1'b0;
            end else begin
              // First half: snapshot both bytes
              s_next.rdata = s_reg.value[7:0];
              s_next.rbuf = s_reg.value;
              s_next.rlatched = 1'b1;
              s_next.rlatch_hi = 1'b0;
            end
          end else begin
            // Live contents, latch untouched in debug
            s_next.rdata = s_reg.value[7:0];
          end
        end
        default: s_next.rdata = 8'h00;
      endcase
    end

    // Register writes
    if (bus.wr) begin
      case (bus.addr)
        tpc_pkg::TPC_ADDR_TSC: begin
          // Counter and other registers untouched
          s_next.center = bus.wdata[tpc_pkg::TPC_TSC_CENTER];
          s_next.clks = {bus.wdata[tpc_pkg::TPC_TSC_CLKS_HI],
                         bus.wdata[tpc_pkg::TPC_TSC_CLKS_LO]};
        end
        tpc_pkg::TPC_ADDR_CNTH,
        tpc_pkg::TPC_ADDR_CNTL: begin
          // Any counter write restarts the count
          s_next.count = tpc_pkg::TPC_CNT_ZERO;
          s_next.count_up = 1'b1;
        end
        tpc_pkg::TPC_ADDR_MODH: s_next.modulo[15:8] = bus.wdata;
        tpc_pkg::TPC_ADDR_MODL: s_next.modulo[7:0] = bus.wdata;
        tpc_pkg::TPC_ADDR_CSC: begin
          s_next.irq_en = bus.wdata[tpc_pkg::TPC_CSC_IRQ_EN];
          s_next.msel = {bus.wdata[tpc_pkg::TPC_CSC_MS_HI],
                         bus.wdata[tpc_pkg::TPC_CSC_MS_LO]};
          s_next.els = {bus.wdata[tpc_pkg::TPC_CSC_EL_HI],
                        bus.wdata[tpc_pkg::TPC_CSC_EL_LO]};
          // Zero written after an armed read clears; one is ignored
          if (s_reg.flag_armed && !bus.wdata[tpc_pkg::TPC_CSC_FLAG]) begin
            s_next.flag = 1'b0;
          end
          s_next.flag_armed = 1'b0;
          // Both coherency latches drop, even in debug
          s_next.rlatched = 1'b0;
          s_next.whi_done = 1'b0;
          s_next.wlo_done = 1'b0;
          s_next.wpend = 1'b0;
        end
        tpc_pkg::TPC_ADDR_VALH: begin
          if (mode == tpc_pkg::TPC_MODE_CAPTURE) begin
            s_next.value = s_reg.value;
          end else if (debug_mode) begin
            // Bypass the buffer, latches kept
            s_next.value[15:8] = bus.wdata;
          end else begin
            s_next.wbuf_hi = bus.wdata;
            s_next.whi_done = 1'b1;
          end
        end
        tpc_pkg::TPC_ADDR_VALL: begin
          if (mode == tpc_pkg::TPC_MODE_CAPTURE) begin
            s_next.value = s_reg.value;
          end else if (debug_mode) begin
            // Bypass the buffer, latches kept
            s_next.value[7:0] = bus.wdata;
          end else begin
            s_next.wbuf_lo = bus.wdata;
            s_next.wlo_done = 1'b1;
          end
        end
        default: s_next.rdata = 8'h00;
      endcase
    end

    // Both halves written: sequence complete, transfer pending
    if (s_next.whi_done && s_next.wlo_done) begin
      s_next.whi_done = 1'b0;
      s_next.wlo_done = 1'b0;
      s_next.wpend = 1'b1;
    end

    // Buffered transfer into the active register
    if (s_next.wpend) begin
      if (s_reg.clks == tpc_pkg::TPC_CLKS_OFF) begin
        s_next.value = {s_next.wbuf_hi, s_next.wbuf_lo};
        s_next.wpend = 1'b0;
      end else if (s_reg.wpend &&
                   mode == tpc_pkg::TPC_MODE_COMPARE && tick) begin
        s_next.value = {s_reg.wbuf_hi, s_reg.wbuf_lo};
        s_next.wpend = 1'b0;
      end else if (s_reg.wpend && pwm_load) begin
        s_next.value = {s_reg.wbuf_hi, s_reg.wbuf_lo};
        s_next.wpend = 1'b0;
      end
    end

    // Capture copies the counter, live even in debug
    if (cap_evt) begin
      s_next.value = s_reg.count;
    end

    // Event sets the flag and cancels a pending clear
    if (evt) begin
      s_next.flag = 1'b1;
      s_next.flag_armed = 1'b0;
    end

    // Pin drive per mode
    case (mode)
      tpc_pkg::TPC_MODE_COMPARE: begin
        s_next.pin_oe = 1'b1;
        if (match) begin
          case (s_reg.els)
            tpc_pkg::TPC_EL_TOGGLE: s_next.pin_out = ~s_reg.pin_out;
            tpc_pkg::TPC_EL_CLEAR: s_next.pin_out = 1'b0;
            tpc_pkg::TPC_EL_SET: s_next.pin_out = 1'b1;
            default: s_next.pin_out = s_reg.pin_out;
          endcase
        end
      end
      tpc_pkg::TPC_MODE_EDGE_ALIGNED_PWM,
      tpc_pkg::TPC_MODE_CENTER_ALIGNED_PWM: begin
        s_next.pin_oe = 1'b1;
        if (tick) begin
          s_next.pin_out = pwm_lvl;
        end
      end
      tpc_pkg::TPC_MODE_CAPTURE: begin
        s_next.pin_oe = 1'b0;
        s_next.pin_out = 1'b0;
      end
      default: begin
        // Pin handed back to general purpose use
        s_next.pin_oe = 1'b0;
        s_next.pin_out = 1'b0;
      end
    endcase
  end

  // State register; reset clears values and clock select
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_reg <= tpc_pkg::TPC_STATE_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs straight from the state register
  assign rdata = s_reg.rdata;
  assign chan_pin_out = s_reg.pin_out;
  assign chan_pin_oe = s_reg.pin_oe;
  assign chan_event_flag = s_reg.flag;

endmodule
`default_nettype wire

// file: verilog/tpc_pkg.sv
// Package of constants and carrier types for the timer channel block
// Behaviour
// - Edge/level 00 releases pin from timer
// - Capture on rising, falling or both edges
// - Compare match toggles, clears or sets pin
// - Edge PWM high-true or low-true pulses
// - Center mode forces center PWM, polarity from low bit
// - Reset clears both value bytes
// - Capture reads latch both bytes coherently
// - Status/control write resets both latches
// - Value writes ignored in capture mode
// - Debug freezes read latch, reads live
// - No clock: load on second byte
// - Compare mode loads on next count
// - PWM loads at terminal minus one step
// - Debug writes go straight to register
// - Debug writes spare pending buffered sequence
// - Center mode counts up and down
// - Clock select 00 off, 01 bus
// - Clock select resets 00, harmless write
// - Active edge captures counter, sets flag
// - Match sets flag except 0%/100% PWM
// - Read-then-write-zero clears flag, set wins
// - Edge PWM polarity follows low bit
package tpc_pkg;

  // Register addresses on the plain port
  localparam logic [2:0] TPC_ADDR_TSC = 3'h0;
  localparam logic [2:0] TPC_ADDR_CNTH = 3'h1;
  localparam logic [2:0] TPC_ADDR_CNTL = 3'h2;
  localparam logic [2:0] TPC_ADDR_MODH = 3'h3;
  localparam logic [2:0] TPC_ADDR_MODL = 3'h4;
  localparam logic [2:0] TPC_ADDR_CSC = 3'h5;
  localparam logic [2:0] TPC_ADDR_VALH = 3'h6;
  localparam logic [2:0] TPC_ADDR_VALL = 3'h7;

  // Timer status/control field positions
  localparam int TPC_TSC_CENTER = 5;
  localparam int TPC_TSC_CLKS_HI = 4;
  localparam int TPC_TSC_CLKS_LO = 3;

  // Channel status/control field positions
  localparam int TPC_CSC_FLAG = 7;
  localparam int TPC_CSC_IRQ_EN = 6;
  localparam int TPC_CSC_MS_HI = 5;
  localparam int TPC_CSC_MS_LO = 4;
  localparam int TPC_CSC_EL_HI = 3;
  localparam int TPC_CSC_EL_LO = 2;

  // Clock select codes
  localparam logic [1:0] TPC_CLKS_OFF = 2'h0;
  localparam logic [1:0] TPC_CLKS_BUS = 2'h1;

  // Edge/level and mode-select codes
  localparam logic [1:0] TPC_EL_NONE = 2'h0;
  localparam logic [1:0] TPC_EL_TOGGLE = 2'h1;
  localparam logic [1:0] TPC_EL_CLEAR = 2'h2;
  localparam logic [1:0] TPC_EL_SET = 2'h3;
  localparam logic [1:0] TPC_MS_CAPTURE = 2'h0;
  localparam logic [1:0] TPC_MS_COMPARE = 2'h1;

  // Counter limits
  localparam logic [15:0] TPC_CNT_MAX = 16'hFFFF;
  localparam logic [15:0] TPC_CNT_ZERO = 16'h0000;
  localparam logic [15:0] TPC_CNT_ONE = 16'h0001;

  // Channel operating modes
  typedef enum logic [2:0] {
    TPC_MODE_OFF,
    TPC_MODE_CAPTURE,
    TPC_MODE_COMPARE,
    TPC_MODE_EDGE_ALIGNED_PWM,
    TPC_MODE_CENTER_ALIGNED_PWM
  } tpc_mode_t;

  // Register port request
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } tpc_bus_req_t;

  // Pin synchroniser state
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
    logic rise;
    logic fall;
  } tpc_sync_t;

  // Whole channel state
  typedef struct packed {
    logic [7:0] rdata;
    logic pin_out;
    logic pin_oe;
    logic center;
    logic [1:0] clks;
    logic [15:0] count;
    logic count_up;
    logic [15:0] modulo;
    logic flag;
    logic flag_armed;
    logic irq_en;
    logic [1:0] msel;
    logic [1:0] els;
    logic [15:0] value;
    logic [7:0] wbuf_hi;
    logic [7:0] wbuf_lo;
    logic whi_done;
    logic wlo_done;
    logic wpend;
    logic rlatched;
    logic rlatch_hi;
    logic [15:0] rbuf;
  } tpc_state_t;

  // Reset values
  localparam tpc_sync_t TPC_SYNC_RST = '0;
  localparam tpc_state_t TPC_STATE_RST = '0;

endpackage

// file: verilog/tpc_pin_sync.sv
// Three-stage pin synchroniser with qualified edge pulses
`timescale 1ns/1ps
`default_nettype none
module tpc_pin_sync (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Raw pin
  input wire logic pin,
  // Clean level and one-cycle edges
  output logic level,
  output logic rise,
  output logic fall
);

  tpc_pkg::tpc_sync_t s_reg; // Current state
  tpc_pkg::tpc_sync_t s_next; // Next state

  // Shift chain; level moves only when stages two and three agree
  always_comb begin
    s_next = s_reg;
    s_next.s1 = pin;
    s_next.s2 = s_reg.s1;
    s_next.s3 = s_reg.s2;
    s_next.rise = 1'b0;
    s_next.fall = 1'b0;
    if (s_reg.s2 == s_reg.s3 && s_reg.s3 != s_reg.level) begin
      s_next.level = s_reg.s3;
      s_next.rise = s_reg.s3;
      s_next.fall = ~s_reg.s3;
    end
  end

  // State register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_reg <= tpc_pkg::TPC_SYNC_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  assign level = s_reg.level;
  assign rise = s_reg.rise;
  assign fall = s_reg.fall;

endmodule
`default_nettype wire

// file: bench/tpc_channel_monitor.sv
// Port-level assertion checker for the timer channel
`timescale 1ns/1ps
`default_nettype none
module tpc_channel_monitor (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Register port
  input wire tpc_pkg::tpc_bus_req_t bus,
  input wire logic [7:0] rdata,
  // Debug halt and alternate tick
  input wire logic debug_mode,
  input wire logic ext_tick,
  // Pin and flag
  input wire logic chan_pin_in,
  input wire logic chan_pin_out,
  input wire logic chan_pin_oe,
  input wire logic chan_event_flag
);
  logic [7:0] csc_reg; // Shadow of channel control bits
  logic [7:0] tsc_reg; // Shadow of timer control bits
  logic was_cap_reg; // Capture mode one cycle ago
  logic was_cmp_reg; // Compare mode one cycle ago
  logic was_off_reg; // Pin released one cycle ago
  logic was_stop_reg; // Counter clock off one cycle ago
  logic is_off; // Edge/level bits clear
  logic is_cap; // Capture mode now
  logic is_cmp; // Compare mode now
  logic is_stop; // No counter clock now
  // Mode decode from the shadows
  assign is_off = csc_reg[3:2] == 2'h0;
  assign is_cap = !tsc_reg[5] && csc_reg[5:4] == 2'h0 && !is_off;
  assign is_cmp = !tsc_reg[5] && csc_reg[5:4] == 2'h1 && !is_off;
  assign is_stop = tsc_reg[4:3] == 2'h0;
  // Shadows follow software writes
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      csc_reg <= 8'h00;
      tsc_reg <= 8'h00;
      was_cap_reg <= 1'b0;
      was_cmp_reg <= 1'b0;
      was_off_reg <= 1'b1;
      was_stop_reg <= 1'b1;
    end else begin
      if (bus.wr && bus.addr == tpc_pkg::TPC_ADDR_CSC) begin
        csc_reg <= bus.wdata & 8'h7C;
      end
      if (bus.wr && bus.addr == tpc_pkg::TPC_ADDR_TSC) begin
        tsc_reg <= bus.wdata & 8'h38;
      end
      was_cap_reg <= is_cap;
      was_cmp_reg <= is_cmp;
      was_off_reg <= is_off;
      was_stop_reg <= is_stop;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Active edge seen while capturing with the flag clear
  sequence edge_armed;
    is_cap && was_cap_reg && !chan_event_flag &&
      ((csc_reg[2] && $rose(chan_pin_in)) ||
       (csc_reg[3] && $fell(chan_pin_in)));
  endsequence
  // Flag follows within the synchroniser delay
  sequence capture_seen;
    ##[1:6] chan_event_flag;
  endsequence
  a_rdata_idle: assert property (!$past(bus.rd) |-> rdata == 8'h00)
    else $error("read data not zero outside read answer");
  a_tsc_readback: assert property (
    $past(bus.rd && bus.addr == tpc_pkg::TPC_ADDR_TSC)
      |-> rdata == $past(tsc_reg))
    else $error("timer control read back wrong");
  a_csc_readback: assert property (
    $past(bus.rd && bus.addr == tpc_pkg::TPC_ADDR_CSC)
      |-> rdata[6:0] == $past(csc_reg[6:0]))
    else $error("channel control read back wrong");
  a_off_release: assert property (
    is_off && was_off_reg |-> !chan_pin_oe)
    else $error("pin driven while released");
  a_cap_input: assert property (
    is_cap && was_cap_reg |-> !chan_pin_oe)
    else $error("pin driven in capture mode");
  a_cmp_drive: assert property (is_cmp && was_cmp_reg |-> chan_pin_oe)
    else $error("pin not driven in compare mode");
  a_stop_hold: assert property (
    is_cmp && was_cmp_reg && is_stop && was_stop_reg
      |-> $stable(chan_pin_out))
    else $error("compare output moved with clock off");
  a_flag_clear: assert property (
    $fell(chan_event_flag) |-> $past(bus.wr &&
      bus.addr == tpc_pkg::TPC_ADDR_CSC && !bus.wdata[7]))
    else $error("flag dropped without clearing write");
  a_capture_edge: assert property (edge_armed |-> capture_seen)
    else $error("active edge did not set flag");
endmodule
bind tpc_channel tpc_channel_monitor tpc_channel_monitor_inst (
  .clk(clk), .reset_n(reset_n), .bus(bus), .rdata(rdata),
  .debug_mode(debug_mode), .ext_tick(ext_tick),
  .chan_pin_in(chan_pin_in), .chan_pin_out(chan_pin_out),
  .chan_pin_oe(chan_pin_oe), .chan_event_flag(chan_event_flag));
`default_nettype wire

// file: bench/tpc_pin_model.sv
// Outside party on the channel pin line
`timescale 1ns/1ps
`default_nettype none
module tpc_pin_model (
  // Level the outside party puts on the line
  input wire logic drive_level,
  // Block side of the line
  input wire logic chan_pin_out,
  input wire logic chan_pin_oe,
  // Resolved line level
  output logic pin_line
);
  // Block wins while it drives, else the outside party
  assign pin_line = chan_pin_oe ? chan_pin_out : drive_level;
endmodule
`default_nettype wire

// file: bench/tpc_channel_tb.sv
// Self-checking testbench for the timer channel
`timescale 1ns/1ps
`default_nettype none
module tpc_channel_tb;
  logic clk; // Bus clock
  logic reset_n; // Async reset
  tpc_pkg::tpc_bus_req_t bus; // Register request
  logic [7:0] rdata; // Read answer
  logic debug_mode; // Debug halt
  logic ext_tick; // External tick source
  logic pin_level; // Outside party level
  logic pin_line; // Resolved pin
  logic pin_out; // Block pin drive
  logic pin_oe; // Block pin enable
  logic flag; // Channel event flag
  logic [7:0] rv; // Last read value
  int mismatches; // Mismatch count
  int n_compared; // Comparison count
  tpc_channel tpc_channel_inst (.clk(clk), .reset_n(reset_n), .bus(bus),
    .rdata(rdata), .debug_mode(debug_mode), .ext_tick(ext_tick),
    .chan_pin_in(pin_line), .chan_pin_out(pin_out), .chan_pin_oe(pin_oe),
    .chan_event_flag(flag));
  tpc_pin_model tpc_pin_model_inst (.drive_level(pin_level),
    .chan_pin_out(pin_out), .chan_pin_oe(pin_oe), .pin_line(pin_line));
  // Clock generator
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Compare and report
  task automatic check(input string what, input logic [15:0] seen,
      input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  // One-cycle register write
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask
  // One-cycle register read, data taken in the answer cycle
  task automatic rd(input logic [2:0] a);
    @(posedge clk);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge clk);
    bus.rd <= 1'b0;
    @(negedge clk);
    rv = rdata;
  endtask
  // Wait for the flag under a bound
  task automatic wait_flag();
    for (int i = 0; i < 64 && flag !== 1'b1; i++) @(negedge clk);
  endtask
  // Count pin high cycles over a span
  task automatic high_count(input int n, output int c);
    c = 0;
    repeat (n) begin
      @(negedge clk);
      c += (pin_out === 1'b1);
    end
  endtask
  // Reset values
  task automatic t_reset();
    rd(tpc_pkg::TPC_ADDR_VALH);
    check("value high", rv, 8'h00);
    rd(tpc_pkg::TPC_ADDR_VALL);
    check("value low", rv, 8'h00);
    rd(tpc_pkg::TPC_ADDR_TSC);
    check("timer control", rv, 8'h00);
  endtask
  // Toggle, clear and set on match with the clock running
  task automatic t_compare();
    logic [7:0] code [3] = '{8'h14, 8'h18, 8'h1C};
    logic [7:0] val [3] = '{8'h20, 8'h40, 8'h60};
    logic pin [3] = '{1'b1, 1'b0, 1'b1};
    wr(tpc_pkg::TPC_ADDR_CNTH, 8'h00);
    wr(tpc_pkg::TPC_ADDR_TSC, 8'h08);
    for (int i = 0; i < 3; i++) begin
      wr(tpc_pkg::TPC_ADDR_CSC, code[i]);
      wr(tpc_pkg::TPC_ADDR_VALH, 8'h00);
      wr(tpc_pkg::TPC_ADDR_VALL, val[i]);
      wait_flag();
      check("match flag", flag, 1'b1);
      check("compare pin", pin_out, pin[i]);
      rd(tpc_pkg::TPC_ADDR_CSC);
      wr(tpc_pkg::TPC_ADDR_CSC, code[i]);
      @(negedge clk);
      check("cleared flag", flag, 1'b0);
    end
  endtask
  // Buffered and debug-mode value writes with no clock
  task automatic t_debug_write();
    wr(tpc_pkg::TPC_ADDR_TSC, 8'h00);
    wr(tpc_pkg::TPC_ADDR_VALH, 8'h55);
    rd(tpc_pkg::TPC_ADDR_VALH);
    check("half-written high", rv, 8'h00);
    @(posedge clk);
    debug_mode <= 1'b1;
    wr(tpc_pkg::TPC_ADDR_VALL, 8'h77);
    rd(tpc_pkg::TPC_ADDR_VALL);
    check("debug low", rv, 8'h77);
    rd(tpc_pkg::TPC_ADDR_VALH);
    check("debug high", rv, 8'h00);
    @(posedge clk);
    debug_mode <= 1'b0;
    wr(tpc_pkg::TPC_ADDR_VALL, 8'h66);
    rd(tpc_pkg::TPC_ADDR_VALH);
    check("finished high", rv, 8'h55);
    rd(tpc_pkg::TPC_ADDR_VALL);
    check("finished low", rv, 8'h66);
  endtask
  // Capture on both edges with a coherent split read
  task automatic t_capture();
    wr(tpc_pkg::TPC_ADDR_CNTH, 8'h00);
    wr(tpc_pkg::TPC_ADDR_CSC, 8'h0C);
    repeat (8) @(posedge clk);
    rd(tpc_pkg::TPC_ADDR_CSC);
    wr(tpc_pkg::TPC_ADDR_CSC, 8'h0C);
    pin_level <= 1'b1;
    wait_flag();
    check("capture flag", flag, 1'b1);
    rd(tpc_pkg::TPC_ADDR_VALH);
    check("captured high", rv, 8'h00);
    wr(tpc_pkg::TPC_ADDR_TSC, 8'h08);
    repeat (300) @(posedge clk);
    pin_level <= 1'b0;
    repeat (8) @(posedge clk);
    wr(tpc_pkg::TPC_ADDR_VALH, 8'hFF);
    rd(tpc_pkg::TPC_ADDR_VALL);
    check("latched low", rv, 8'h00);
    rd(tpc_pkg::TPC_ADDR_VALH);
    check("second capture", rv, 8'h01);
  endtask
  // External tick source, then a stop that keeps the count
  task automatic t_clock_src();
    wr(tpc_pkg::TPC_ADDR_TSC, 8'h10);
    wr(tpc_pkg::TPC_ADDR_CNTH, 8'h00);
    repeat (5) @(posedge clk);
    ext_tick <= 1'b1;
    repeat (3) @(posedge clk);
    ext_tick <= 1'b0;
    wr(tpc_pkg::TPC_ADDR_TSC, 8'h00);
    rd(tpc_pkg::TPC_ADDR_CNTL);
    check("external ticks", rv, 8'h03);
  endtask
  // Edge and center PWM duty, then pin release
  task automatic t_pwm();
    int c;
    wr(tpc_pkg::TPC_ADDR_TSC, 8'h00);
    wr(tpc_pkg::TPC_ADDR_CSC, 8'h28);
    wr(tpc_pkg::TPC_ADDR_MODH, 8'h00);
    wr(tpc_pkg::TPC_ADDR_MODL, 8'h09);
    wr(tpc_pkg::TPC_ADDR_CNTH, 8'h00);
    wr(tpc_pkg::TPC_ADDR_VALH, 8'h00);
    wr(tpc_pkg::TPC_ADDR_VALL, 8'h04);
    wr(tpc_pkg::TPC_ADDR_TSC, 8'h08);
    repeat (12) @(negedge clk);
    high_count(20, c);
    check("edge high-true", c, 16'h0008);
    wr(tpc_pkg::TPC_ADDR_CSC, 8'h24);
    repeat (12) @(negedge clk);
    high_count(20, c);
    check("edge low-true", c, 16'h000C);
    wr(tpc_pkg::TPC_ADDR_CSC, 8'h28);
    wr(tpc_pkg::TPC_ADDR_TSC, 8'h28);
    repeat (20) @(negedge clk);
    high_count(36, c);
    check("center high-true", c, 16'h000E);
    wr(tpc_pkg::TPC_ADDR_CSC, 8'h00);
    repeat (3) @(negedge clk);
    check("released pin", pin_oe, 1'b0);
  endtask
  // Verdict and end of run
  task automatic give_verdict();
    $display("compared %0d, mismatched %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Hang guard
  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    give_verdict();
  end
  // Main sequence
  initial begin
    reset_n = 1'b0;
    bus = '0;
    debug_mode = 1'b0;
    ext_tick = 1'b0;
    pin_level = 1'b0;
    mismatches = 0;
    n_compared = 0;
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    t_reset();
    t_compare();
    t_debug_write();
    t_capture();
    t_pwm();
    t_clock_src();
    give_verdict();
  end
endmodule
`default_nettype wire
